// [core/ofp_pkg.sv]
// package: register map, fields, states and timing for output fallback block
package ofp_pkg;
  localparam int unsigned CLK_HZ = 10_000_000;
  localparam int unsigned N_RELAY = 8;
  localparam int unsigned N_OUT = N_RELAY + 2;
  // register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_MODE = 8'h04;
  localparam logic [7:0] OFF_FB_LEVEL = 8'h08;
  localparam logic [7:0] OFF_OUT_SET = 8'h0c;
  localparam logic [7:0] OFF_OUT_NOW = 8'h10;
  localparam logic [7:0] OFF_STATUS = 8'h14;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h18;
  localparam logic [7:0] OFF_DIAG = 8'h1c;
  // ctrl fields
  localparam int unsigned CTRL_HOLD = 0;
  localparam int unsigned CTRL_NO_REARM = 1;
  localparam int unsigned CTRL_SIX_RELAY = 2;
  localparam int unsigned CTRL_CLR_PROT = 3;
  // status bit positions
  localparam int unsigned ST_FALLBACK = 0;
  localparam int unsigned ST_SHORT0 = 1;
  localparam int unsigned ST_SHORT24 = 2;
  localparam int unsigned ST_PULSE_ERR = 3;
  localparam int unsigned ST_W = 4;
  // reset values
  localparam logic [3:0] CTRL_RST = 4'h0;
  localparam logic [N_OUT-1:0] FB_LEVEL_RST = 10'h000;
  // fast output function per channel
  typedef enum logic [1:0] {
    OFP_FN_PLAIN = 2'h0,
    OFP_FN_TRAIN = 2'h1,
    OFP_FN_WIDTH = 2'h2
  } ofp_fn_t;
  typedef enum logic [1:0] {
    OFP_PR_IDLE = 2'h0,
    OFP_PR_LOCK = 2'h1,
    OFP_PR_RETEST = 2'h3
  } ofp_prot_t;
  // re-arm periods
  localparam int unsigned REARM0_S = 10;
  localparam int unsigned REARM24_US = 200;
  localparam int unsigned REARM0_CYC = REARM0_S * CLK_HZ;
  localparam int unsigned REARM24_CYC = REARM24_US * (CLK_HZ / 1_000_000);
  localparam int unsigned CNT_W = 27;
  typedef struct packed {
    logic [3:0] ctrl;
    ofp_fn_t fn1;
    ofp_fn_t fn0;
    logic [N_OUT-1:0] fb_level;
    logic [N_OUT-1:0] out_set;
    logic [N_OUT-1:0] held;
    logic [N_OUT-1:0] outs;
    logic [ST_W-1:0] status;
    logic [ST_W-1:0] mask;
    logic [1:0] diag;
    logic in_fb;
    ofp_prot_t prot;
    logic prot_24;
    logic [CNT_W-1:0] cnt;
    logic [31:0] prdata;
  } ofp_state_t;
endpackage : ofp_pkg

// [core/ofp_output_fallback_protect.sv]
// output fallback, fast output short-circuit protection and apb registers
`timescale 1ns/100ps
module ofp_output_fallback_protect
  import ofp_pkg::*;
#(
  parameter int unsigned REARM0_CYCLES = REARM0_CYC,
  parameter int unsigned REARM24_CYCLES = REARM24_CYC
) (
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic sys_rst_in,
  // apb slave
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // controller state and supervision
  input wire logic stop_in,
  input wire logic exception_in,
  input wire logic short_0v_in,
  input wire logic short_24v_in,
  input wire logic pulse_supply_ok_in,
  input wire logic sys_power_up_in,
  // pulse generators
  input wire logic [1:0] pulse_wave_in,
  output logic [1:0] train_ramp_stop_out,
  output logic [1:0] train_abort_out,
  // outputs
  output logic fast_out_0,
  output logic fast_out_1,
  output logic [N_RELAY-1:0] relay_out,
  output logic irq_out
);
  ofp_state_t st;
  ofp_state_t next_st;
  logic wr;
  logic rd;
  logic fb_now;
  logic prot_on;
  logic [1:0] pulse_fn;
  logic [N_OUT-1:0] relay_mask;
  logic [N_OUT-1:0] normal;
  logic [N_OUT-1:0] fallback;
  logic [N_OUT-1:0] held_now;
  logic [ST_W-1:0] ev;
  logic pwr_q;
  logic [CNT_W-1:0] period;

  function automatic logic is_pulse(input ofp_fn_t f);
    return f != OFP_FN_PLAIN;
  endfunction : is_pulse

  assign wr = psel_in & penable_in & pwrite_in;
  assign rd = psel_in & ~penable_in & ~pwrite_in;
  assign fb_now = stop_in | exception_in;
  assign prot_on = st.prot != OFP_PR_IDLE;
  assign pulse_fn = {is_pulse(st.fn1), is_pulse(st.fn0)};
  // relays 6 and 7 absent on the six-relay variant
  assign relay_mask = st.ctrl[CTRL_SIX_RELAY] ? 10'h33f : 10'h3ff;
  assign period = st.prot_24 ? CNT_W'(REARM24_CYCLES) : CNT_W'(REARM0_CYCLES);

  always_comb begin
    normal = st.out_set;
    // plain by default; pulse functions take the fast pins
    if (is_pulse(st.fn0)) begin
      normal[N_RELAY] = pulse_wave_in[0];
    end
    if (is_pulse(st.fn1)) begin
      normal[N_RELAY+1] = pulse_wave_in[1];
    end
    // held copy is not captured yet on the entry cycle
    held_now = st.in_fb ? st.held : st.outs;
    // default level or held level
    fallback = st.ctrl[CTRL_HOLD] ? held_now : st.fb_level;
    if (pulse_fn[0]) begin
      fallback[N_RELAY] = 1'b0;
    end
    if (pulse_fn[1]) begin
      fallback[N_RELAY+1] = 1'b0;
    end
  end

  always_comb begin
    next_st = st;
    ev = '0;
    next_st.in_fb = fb_now;
    // capture levels on fallback entry
    if (fb_now && !st.in_fb) begin
      next_st.held = st.outs;
      ev[ST_FALLBACK] = 1'b1;
    end
    next_st.outs = (fb_now ? fallback : normal) & relay_mask;
    // protection acts on fast group only
    case (st.prot)
      OFP_PR_IDLE: begin
        if (short_0v_in || short_24v_in) begin
          next_st.prot = OFP_PR_LOCK;
          next_st.prot_24 = short_24v_in & ~short_0v_in;
          next_st.cnt = '0;
        end
      end
      OFP_PR_LOCK: begin
        if (st.ctrl[CTRL_NO_REARM]) begin
          next_st.cnt = '0;
        end else if (st.cnt >= period - CNT_W'(1)) begin
          next_st.prot = OFP_PR_RETEST;
        end else begin
          next_st.cnt = st.cnt + CNT_W'(1);
        end
      end
      OFP_PR_RETEST: begin
        next_st.cnt = '0;
        if (short_0v_in || short_24v_in) begin
          next_st.prot = OFP_PR_LOCK;
          next_st.prot_24 = short_24v_in & ~short_0v_in;
        end else begin
          next_st.prot = OFP_PR_IDLE;
        end
      end
      default: begin
        next_st.prot = OFP_PR_IDLE;
      end
    endcase
    if (st.prot == OFP_PR_IDLE || st.prot == OFP_PR_RETEST) begin
      ev[ST_SHORT0] = short_0v_in;
      ev[ST_SHORT24] = short_24v_in & ~short_0v_in;
    end
    if (short_0v_in) begin
      next_st.diag[0] = 1'b1;
    end
    if (short_24v_in) begin
      next_st.diag[1] = 1'b1;
    end
    // missing pulse supply at power-up edge
    ev[ST_PULSE_ERR] = sys_power_up_in & ~pwr_q &
      ~pulse_supply_ok_in;
    next_st.prdata = '0;
    if (wr) begin
      case (paddr_in)
        OFF_CTRL: next_st.ctrl = pwdata_in[3:0];
        OFF_MODE: begin
          next_st.fn0 = ofp_fn_t'(pwdata_in[1:0]);
          next_st.fn1 = ofp_fn_t'(pwdata_in[3:2]);
        end
        OFF_FB_LEVEL: next_st.fb_level = pwdata_in[N_OUT-1:0];
        OFF_OUT_SET: next_st.out_set = pwdata_in[N_OUT-1:0];
        OFF_STATUS: next_st.status = st.status & ~pwdata_in[ST_W-1:0];
        OFF_IRQ_MASK: next_st.mask = pwdata_in[ST_W-1:0];
        OFF_DIAG: next_st.diag = st.diag & ~pwdata_in[1:0];
        default: next_st.ctrl = st.ctrl;
      endcase
    end
    // software clear of a locked protection
    if (wr && paddr_in == OFF_CTRL && pwdata_in[CTRL_CLR_PROT]) begin
      next_st.ctrl[CTRL_CLR_PROT] = 1'b0;
      if (st.prot == OFP_PR_LOCK) begin
        next_st.prot = OFP_PR_RETEST;
      end
    end
    if (short_0v_in) begin
      next_st.diag[0] = 1'b1;
    end
    if (short_24v_in) begin
      next_st.diag[1] = 1'b1;
    end
    next_st.status = next_st.status | ev; // set wins over clear
    if (rd) begin
      case (paddr_in)
        OFF_CTRL: next_st.prdata = 32'(st.ctrl);
        OFF_MODE: next_st.prdata = 32'({st.fn1, st.fn0});
        OFF_FB_LEVEL: next_st.prdata = 32'(st.fb_level);
        OFF_OUT_SET: next_st.prdata = 32'(st.out_set);
        OFF_OUT_NOW: next_st.prdata = 32'(st.outs);
        OFF_STATUS: next_st.prdata = 32'(st.status);
        OFF_IRQ_MASK: next_st.prdata = 32'(st.mask);
        OFF_DIAG: next_st.prdata = 32'({st.prot_24, prot_on, st.diag});
        default: next_st.prdata = '0;
      endcase
    end
  end

  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      st <= '{ctrl: CTRL_RST, fn1: OFP_FN_PLAIN, fn0: OFP_FN_PLAIN,
              fb_level: FB_LEVEL_RST, prot: OFP_PR_IDLE, default: '0};
      pwr_q <= 1'b0;
    end else begin
      st <= next_st;
      pwr_q <= sys_power_up_in;
    end
  end

  // protection forces fast pins off, relays untouched
  assign fast_out_0 = st.outs[N_RELAY] & ~prot_on;
  assign fast_out_1 = st.outs[N_RELAY+1] & ~prot_on;
  assign relay_out = st.outs[N_RELAY-1:0];
  assign train_ramp_stop_out = {2{fb_now & ~prot_on}} &
    {st.fn1 == OFP_FN_TRAIN, st.fn0 == OFP_FN_TRAIN};
  assign train_abort_out = {2{prot_on}} &
    {st.fn1 == OFP_FN_TRAIN, st.fn0 == OFP_FN_TRAIN};
  assign irq_out = |(st.status & st.mask);
  assign prdata_out = st.prdata;
  assign pready_out = psel_in & penable_in;
  assign pslverr_out = 1'b0;

  a_fast_forced_off: assert property (@(posedge clk_sys_in)
    disable iff (sys_rst_in) prot_on |-> !fast_out_0 && !fast_out_1)
    else $error("fast output high during protection");
  a_short_locks: assert property (@(posedge clk_sys_in)
    disable iff (sys_rst_in)
    (st.prot == OFP_PR_IDLE && (short_0v_in || short_24v_in)) |=>
    st.prot == OFP_PR_LOCK)
    else $error("short did not lock protection");
  a_no_rearm_hold: assert property (@(posedge clk_sys_in)
    disable iff (sys_rst_in)
    (st.prot == OFP_PR_LOCK && st.ctrl[CTRL_NO_REARM] && !wr) |=>
    st.prot == OFP_PR_LOCK)
    else $error("re-arm while inhibited");
  a_pulse_fb_zero: assert property (@(posedge clk_sys_in)
    disable iff (sys_rst_in)
    (fb_now && pulse_fn[0]) |=> !st.outs[N_RELAY])
    else $error("pulse output not zero on fallback");
  a_default_level: assert property (@(posedge clk_sys_in)
    disable iff (sys_rst_in)
    (fb_now && !st.ctrl[CTRL_HOLD] && !pulse_fn[0] && !wr) |=>
    st.outs[0] == $past(st.fb_level[0]))
    else $error("default level not driven");
  a_hold_level: assert property (@(posedge clk_sys_in)
    disable iff (sys_rst_in)
    (st.in_fb && fb_now && st.ctrl[CTRL_HOLD] && !wr) |=>
    $stable(st.outs[0]))
    else $error("held output changed");
  a_ramp_req: assert property (@(posedge clk_sys_in)
    disable iff (sys_rst_in)
    (fb_now && st.fn0 == OFP_FN_TRAIN && !prot_on) |-> train_ramp_stop_out[0])
    else $error("no ramp request on fallback");
  a_pulse_err: assert property (@(posedge clk_sys_in)
    disable iff (sys_rst_in)
    (sys_power_up_in && !pwr_q && !pulse_supply_ok_in) |=>
    st.status[ST_PULSE_ERR])
    else $error("pulse error not flagged");
  a_diag_sets: assert property (@(posedge clk_sys_in)
    disable iff (sys_rst_in) short_24v_in |=> st.diag[1])
    else $error("diag not set");
  a_six_relays: assert property (@(posedge clk_sys_in)
    disable iff (sys_rst_in)
    $past(st.ctrl[CTRL_SIX_RELAY]) |-> relay_out[7:6] == 2'h0)
    else $error("absent relays driven");
endmodule : ofp_output_fallback_protect

// [sim/ofp_load_model.sv]
// load model: fast output loads with commanded short faults
`timescale 1ns/100ps
module ofp_load_model (
  // from the block
  input wire logic fast_0_in,
  input wire logic fast_1_in,
  // fault commands from the bench
  input wire logic fault_0v_in,
  input wire logic fault_24v_in,
  // sense lines
  output logic short_0v_out,
  output logic short_24v_out
);
  // a short shows only while a fast output sources current
  assign short_0v_out = fault_0v_in & (fast_0_in | fast_1_in);
  assign short_24v_out = fault_24v_in & (fast_0_in | fast_1_in);
endmodule : ofp_load_model

// [sim/ofp_output_fallback_protect_tb.sv]
// testbench: fallback table, protection, interrupts, variants
`timescale 1ns/100ps
`define CHK(n, e, s) begin check_count++; if ((s) !== (e)) begin \
  err_count++; $display("BAD %s exp %h got %h", n, e, s); end end
module ofp_output_fallback_protect_tb;
  import ofp_pkg::*;
  typedef struct packed {
    logic hold;
    logic exc;
    logic [9:0] fb;
    logic [3:0] mode;
    logic [9:0] exp;
    logic [1:0] ramp;
  } ofp_row_t;
  logic clk_sys_in, sys_rst_in, psel, penable, pwrite, stop, exc, slverr;
  logic f0v, f24v, s0, s24, supply_ok, power_up, pready, fo0, fo1, irq;
  logic [1:0] wave, ramp, abrt;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [N_RELAY-1:0] relay;
  int err_count = 0;
  int check_count = 0;
  int cyc = 0;
  ofp_row_t rows [5] = '{
    '{1'b0, 1'b0, 10'h3ff, 4'h0, 10'h3ff, 2'h0},
    '{1'b0, 1'b1, 10'h000, 4'h0, 10'h000, 2'h0},
    '{1'b1, 1'b0, 10'h000, 4'h0, 10'h2a5, 2'h0},
    '{1'b1, 1'b1, 10'h3ff, 4'h5, 10'h0a5, 2'h3},
    '{1'b0, 1'b0, 10'h3ff, 4'ha, 10'h0ff, 2'h0}};

  ofp_output_fallback_protect #(.REARM0_CYCLES(50), .REARM24_CYCLES(20)) uut (
    .clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in), .psel_in(psel),
    .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
    .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
    .pslverr_out(slverr), .stop_in(stop), .exception_in(exc), .short_0v_in(s0),
    .short_24v_in(s24), .pulse_supply_ok_in(supply_ok),
    .sys_power_up_in(power_up), .pulse_wave_in(wave),
    .train_ramp_stop_out(ramp), .train_abort_out(abrt), .fast_out_0(fo0),
    .fast_out_1(fo1), .relay_out(relay), .irq_out(irq));
  ofp_load_model load (
    .fast_0_in(fo0), .fast_1_in(fo1), .fault_0v_in(f0v),
    .fault_24v_in(f24v), .short_0v_out(s0), .short_24v_out(s24));

  initial begin
    clk_sys_in = 1'b0;
    forever #50 clk_sys_in = ~clk_sys_in;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys_in);
  endtask : tick

  // setup, access until pready, release, one idle edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys_in);
    penable <= 1'b1;
    do @(posedge clk_sys_in); while (pready !== 1'b1);
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys_in);
  endtask : apb

  task automatic wrap_up();
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : wrap_up

  always @(posedge clk_sys_in) begin
    cyc++;
    if (cyc == 3000) begin
      err_count++;
      wrap_up();
    end
  end

  initial begin
    {psel, penable, pwrite, stop, exc, f0v, f24v, supply_ok} = '0;
    {power_up, wave, paddr, pwdata} = '0;
    sys_rst_in = 1'b1;
    tick(2);
    sys_rst_in <= 1'b0;
    tick(1);
    `CHK("outs_rst", 10'h000, {fo1, fo0, relay})
    apb(1'b0, OFF_FB_LEVEL, 32'h0);
    `CHK("fb_rst", 32'h0, q)
    apb(1'b0, OFF_MODE, 32'h0);
    `CHK("mode_rst", 32'h0, q)
    apb(1'b0, 8'h40, 32'h0);
    `CHK("unmapped", 32'h0, q)
    `CHK("slverr", 1'b0, slverr)
    foreach (rows[i]) begin
      apb(1'b1, OFF_CTRL, {31'h0, rows[i].hold});
      apb(1'b1, OFF_MODE, {28'h0, rows[i].mode});
      apb(1'b1, OFF_FB_LEVEL, {22'h0, rows[i].fb});
      apb(1'b1, OFF_OUT_SET, 32'h2a5);
      stop <= ~rows[i].exc;
      exc <= rows[i].exc;
      tick(3);
      `CHK("outs", rows[i].exp, {fo1,fo0,relay})
      `CHK("ramp", rows[i].ramp, ramp)
      stop <= 1'b0;
      exc <= 1'b0;
      tick(2);
    end
    apb(1'b1, OFF_CTRL, 32'h0);
    apb(1'b1, OFF_MODE, 32'h1);
    apb(1'b1, OFF_OUT_SET, 32'h3ff);
    wave <= 2'h3;
    tick(2);
    `CHK("plain", 1'b1, fo1)
    f0v <= 1'b1;
    tick(3);
    f0v <= 1'b0;
    `CHK("lock0", 3'b011, {fo1, abrt[0], relay[0]})
    apb(1'b0, OFF_DIAG, 32'h0);
    `CHK("diag", 4'h5, q[3:0])
    tick(20);
    `CHK("wait0", 1'b0, fo1)
    tick(35);
    `CHK("rearm0", 1'b1, fo1)
    f24v <= 1'b1;
    tick(3);
    f24v <= 1'b0;
    tick(5);
    `CHK("lock24", 1'b0, fo1)
    tick(20);
    `CHK("rearm24", 1'b1, fo1)
    apb(1'b1, OFF_CTRL, 32'h2);
    f0v <= 1'b1;
    tick(3);
    f0v <= 1'b0;
    tick(60);
    `CHK("inhibit", 1'b0, fo1)
    apb(1'b1, OFF_CTRL, 32'ha);
    tick(4);
    `CHK("cleared", 1'b1, fo1)
    power_up <= 1'b1;
    tick(2);
    apb(1'b0, OFF_STATUS, 32'h0);
    `CHK("status", 4'hf, q[3:0])
    `CHK("irq_masked", 1'b0, irq)
    apb(1'b1, OFF_IRQ_MASK, 32'hf);
    tick(1);
    `CHK("irq_on", 1'b1, irq)
    apb(1'b1, OFF_STATUS, 32'hf);
    tick(1);
    `CHK("irq_off", 1'b0, irq)
    apb(1'b1, OFF_CTRL, 32'h4);
    tick(2);
    `CHK("six", 8'h3f, relay)
    apb(1'b0, OFF_OUT_NOW, 32'h0);
    `CHK("out_now", 32'h33f, q)
    wrap_up();
  end
endmodule : ofp_output_fallback_protect_tb
